// *** hdl/wdcm_clkmon.sv ***
// clock monitor: flags a gap between instruction cycles longer than the limit
`timescale 1ns/1ns
`default_nettype none
module wdcm_clkmon #(
	parameter int LIMIT = 250000
) (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic enable,
	input  wire logic tc_tick,
	output logic      fail_r
);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] cnt_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_r  <= '0;
			fail_r <= 1'h0;
		end else if (!enable || tc_tick) begin
			cnt_r  <= '0;
			fail_r <= 1'h0;
		end else if (cnt_r == CW'(LIMIT - 1)) begin
			fail_r <= 1'h1;
		end else begin
			cnt_r <= cnt_r + CW'(1);
		end
	end

	clk_gap_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(fail_r) |-> $past(cnt_r) == CW'(LIMIT - 1) && $past(enable))
		else $error("clock fail raised without a full gap");
endmodule
`default_nettype wire

// *** hdl/wdcm_pkg.sv ***
// types and the helper function of the watchdog and clock monitor
`include "wdcm_regs.svh"
package wdcm_pkg;
	typedef enum logic [1:0] {WD_RUN, WD_DRIVE, WD_HOLD, WD_WAIT} wdcm_state_t;
	typedef logic [1:0] wdcm_win_t;
	typedef logic [`WDCM_CNT_W-1:0] wdcm_cnt_t;

	function automatic wdcm_cnt_t wdcm_upper(input wdcm_win_t win);
		wdcm_upper = `WDCM_UPPER_BASE_TC << win;
	endfunction
endpackage

// *** hdl/wdcm_regs.svh ***
// register offsets, field positions, reset values and counts of the watchdog and clock monitor
`ifndef WDCM_REGS_SVH
`define WDCM_REGS_SVH
`define WDCM_ADDR_W          8
`define WDCM_DATA_W          8
`define WDCM_SVC_ADDR        8'hC7
`define WDCM_CTRL_ADDR       8'h90
`define WDCM_STAT_ADDR       8'h91
`define WDCM_ITMR_LO_ADDR    8'h92
`define WDCM_ITMR_HI_ADDR    8'h93
`define WDCM_WIN_HI          7
`define WDCM_WIN_LO          6
`define WDCM_KEY_HI          5
`define WDCM_KEY_LO          1
`define WDCM_CM_BIT          0
`define WDCM_KEY             5'h0C
`define WDCM_KEY_READ        5'h00
`define WDCM_WIN_RESET       2'h3
`define WDCM_CM_RESET        1'h1
`define WDCM_CTRL_CLOCK_DELAY_SELECT_BIT 0
`define WDCM_STAT_PND_BIT    0
`define WDCM_STAT_FAULT_BIT  1
`define WDCM_STAT_CLKF_BIT   2
`define WDCM_STAT_LOCK_BIT   3
`define WDCM_CNT_W           17
`define WDCM_CNT_ONE         17'h00001
`define WDCM_LOWER_TC        17'h00100
`define WDCM_UPPER_BASE_TC   17'h02000
`define WDCM_HOLD_W          5
`define WDCM_HOLD_TC         5'h10
`define WDCM_HOLD_ONE        5'h01
`define WDCM_ITMR_W          16
`define WDCM_ITMR_ONE        16'h0001
`define WDCM_ITMR_BIT        12
`define WDCM_CLK_PERIOD_NS   4
`define WDCM_CLKMON_LIMIT_NS 1000000
`endif

// *** hdl/wdcm_tick.sv ***
// instruction cycle enable taken from the oscillator pin
`timescale 1ns/1ns
`default_nettype none
module wdcm_tick (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic osc_pin,
	output logic      tc_tick
);
	logic sync1_r;
	logic sync2_r;
	logic last_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 1'h0;
			sync2_r <= 1'h0;
			last_r  <= 1'h0;
		end else begin
			sync1_r <= osc_pin;
			sync2_r <= sync1_r;
			last_r  <= sync2_r;
		end
	end

	// one pulse per rising oscillator edge
	assign tc_tick = sync2_r & ~last_r;
endmodule
`default_nettype wire

// *** hdl/wdcm_top.sv ***
// windowed watchdog with clock monitor, idle timer and register port
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "wdcm_regs.svh"
module wdcm_top #(
	parameter int CLKMON_LIMIT = `WDCM_CLKMON_LIMIT_NS / `WDCM_CLK_PERIOD_NS
) (
	input  wire logic                    clock,
	input  wire logic                    rstn,
	input  wire logic                    por_n,
	input  wire logic                    osc_pin,
	input  wire logic                    halt_mode,
	input  wire logic                    idle_mode,
	input  wire logic                    osc_rc_option,
	input  wire logic [`WDCM_ADDR_W-1:0] reg_addr,
	input  wire logic [`WDCM_DATA_W-1:0] reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [`WDCM_DATA_W-1:0] reg_rdata,
	output logic                         fault_output_pin_out,
	output logic                         fault_output_pin_oe_n,
	input  wire logic                    fault_output_pin_in,
	output logic                         idle_timer_pending
);
	wdcm_pkg::wdcm_state_t           state_r;
	wdcm_pkg::wdcm_state_t           state_nxt;
	wdcm_pkg::wdcm_cnt_t             cnt_r;
	wdcm_pkg::wdcm_win_t             win_r;
	logic                            cm_en_r;
	logic                            first_r;
	logic                            clock_delay_select_r;
	logic [`WDCM_HOLD_W-1:0]         hold_r;
	logic [`WDCM_ITMR_W-1:0]         itmr_r;
	logic [`WDCM_ITMR_W-1:0]         itmr_nxt;
	logic                            pend_r;
	logic                            pin_s1_r;
	logic                            pin_s2_r;
	logic                            halt_d_r;
	logic                            idle_d_r;
	logic                            oe_n_r;
	logic [`WDCM_DATA_W-1:0]         rdata_r;
	logic                            tc_tick;
	logic                            clk_fail;
	logic                            low_power;
	logic                            halt_exit;
	logic                            idle_exit;
	logic                            svc_wr;
	logic                            svc_take;
	logic                            key_ok;
	logic                            win_ok;
	logic                            cm_ok;
	logic                            early;
	logic                            svc_valid;
	logic                            svc_bad;
	logic                            timeout;
	logic                            wd_err;
	logic                            resume;
	logic                            pend_set;
	logic                            pend_clr;
	wdcm_pkg::wdcm_win_t             wr_win;
	logic [`WDCM_KEY_HI-`WDCM_KEY_LO:0] wr_key;
	logic                            wr_cm;

	wdcm_tick u_tick (
		.clock   (clock),
		.rstn    (rstn),
		.osc_pin (osc_pin),
		.tc_tick (tc_tick)
	);

	// not gated by low power so a stopped oscillator in halt is caught
	wdcm_clkmon #(
		.LIMIT (CLKMON_LIMIT)
	) u_clkmon (
		.clock   (clock),
		.rstn    (rstn),
		.enable  (cm_en_r),
		.tc_tick (tc_tick),
		.fail_r  (clk_fail)
	);

	// fault pin readback comes from outside the clock domain
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_s1_r <= 1'h1;
			pin_s2_r <= 1'h1;
		end else begin
			pin_s1_r <= fault_output_pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			halt_d_r <= 1'h0;
			idle_d_r <= 1'h0;
		end else begin
			halt_d_r <= halt_mode;
			idle_d_r <= idle_mode;
		end
	end

	assign low_power = halt_mode | idle_mode;
	assign halt_exit = halt_d_r & ~halt_mode;
	assign idle_exit = idle_d_r & ~idle_mode;

	assign wr_win = reg_wdata[`WDCM_WIN_HI:`WDCM_WIN_LO];
	assign wr_key = reg_wdata[`WDCM_KEY_HI:`WDCM_KEY_LO];
	assign wr_cm  = reg_wdata[`WDCM_CM_BIT];

	assign svc_wr   = reg_wr && (reg_addr == `WDCM_SVC_ADDR);
	assign svc_take = svc_wr && (state_r == wdcm_pkg::WD_RUN) && !low_power;
	assign key_ok   = (wr_key == `WDCM_KEY);
	assign win_ok   = (wr_win == win_r);
	assign cm_ok    = (wr_cm == cm_en_r);
	assign early    = !first_r && (cnt_r < `WDCM_LOWER_TC);
	assign svc_valid = svc_take && key_ok && (first_r || (win_ok && cm_ok)) && !early;
	assign svc_bad   = svc_take && !svc_valid;
	assign timeout   = (state_r == wdcm_pkg::WD_RUN) && !low_power && tc_tick
		&& (cnt_r == wdcm_pkg::wdcm_upper(win_r) - `WDCM_CNT_ONE);
	assign wd_err    = svc_bad || timeout;
	assign resume    = osc_rc_option && !clock_delay_select_r;

	// window count in instruction cycles since the last service
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (state_r != wdcm_pkg::WD_RUN) begin
			cnt_r <= '0;
		end else if (svc_valid) begin
			cnt_r <= '0;
		end else if (idle_exit) begin
			cnt_r <= '0;
		end else if (halt_exit && !resume) begin
			cnt_r <= '0;
		end else if (tc_tick && !low_power) begin
			cnt_r <= cnt_r + `WDCM_CNT_ONE;
		end
	end

	// settings are irrevocable once the first good service lands
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			win_r   <= `WDCM_WIN_RESET;
			cm_en_r <= `WDCM_CM_RESET;
			first_r <= 1'h1;
		end else if (svc_valid && first_r) begin
			win_r   <= wr_win;
			cm_en_r <= wr_cm;
			first_r <= 1'h0;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			wdcm_pkg::WD_RUN: begin
				if (wd_err || clk_fail) begin
					state_nxt = wdcm_pkg::WD_DRIVE;
				end
			end
			wdcm_pkg::WD_DRIVE: begin
				if (!pin_s2_r) begin
					state_nxt = wdcm_pkg::WD_HOLD;
				end
			end
			wdcm_pkg::WD_HOLD: begin
				if (!clk_fail && tc_tick && hold_r == `WDCM_HOLD_TC - `WDCM_HOLD_ONE) begin
					state_nxt = wdcm_pkg::WD_WAIT;
				end
			end
			wdcm_pkg::WD_WAIT: begin
				if (clk_fail) begin
					state_nxt = wdcm_pkg::WD_DRIVE;
				end else if (pin_s2_r) begin
					state_nxt = wdcm_pkg::WD_RUN;
				end
			end
			default: begin
				state_nxt = wdcm_pkg::WD_RUN;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r <= wdcm_pkg::WD_RUN;
			oe_n_r  <= 1'h1;
		end else begin
			state_r <= state_nxt;
			oe_n_r  <= !(state_nxt == wdcm_pkg::WD_DRIVE || state_nxt == wdcm_pkg::WD_HOLD);
		end
	end

	// the hold count restarts while the clock is bad, so release waits for recovery
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_r <= '0;
		end else if (state_r != wdcm_pkg::WD_HOLD || clk_fail) begin
			hold_r <= '0;
		end else if (tc_tick) begin
			hold_r <= hold_r + `WDCM_HOLD_ONE;
		end
	end

	assign fault_output_pin_out  = 1'h0;
	assign fault_output_pin_oe_n = oe_n_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			clock_delay_select_r <= 1'h0;
		end else if (reg_wr && reg_addr == `WDCM_CTRL_ADDR) begin
			clock_delay_select_r <= reg_wdata[`WDCM_CTRL_CLOCK_DELAY_SELECT_BIT];
		end
	end

	// idle timer survives the external reset; only power-on clears it
	assign itmr_nxt = itmr_r + `WDCM_ITMR_ONE;
	always_ff @(posedge clock or negedge por_n) begin
		if (!por_n) begin
			itmr_r <= '0;
		end else if (tc_tick) begin
			itmr_r <= itmr_nxt;
		end
	end

	assign pend_set = tc_tick && (itmr_nxt[`WDCM_ITMR_BIT] != itmr_r[`WDCM_ITMR_BIT]);
	assign pend_clr = reg_wr && reg_addr == `WDCM_STAT_ADDR && reg_wdata[`WDCM_STAT_PND_BIT];
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 1'h0;
		end else if (pend_set) begin
			pend_r <= 1'h1;
		end else if (pend_clr) begin
			pend_r <= 1'h0;
		end
	end

	assign idle_timer_pending = pend_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`WDCM_SVC_ADDR: begin
					rdata_r <= {win_r, `WDCM_KEY_READ, cm_en_r};
				end
				`WDCM_CTRL_ADDR: begin
					rdata_r <= {{(`WDCM_DATA_W-1){1'h0}}, clock_delay_select_r};
				end
				`WDCM_STAT_ADDR: begin
					rdata_r <= {4'h0, !first_r, clk_fail, !oe_n_r, pend_r};
				end
				`WDCM_ITMR_LO_ADDR: begin
					rdata_r <= itmr_r[`WDCM_DATA_W-1:0];
				end
				`WDCM_ITMR_HI_ADDR: begin
					rdata_r <= itmr_r[`WDCM_ITMR_W-1:`WDCM_DATA_W];
				end
				default: begin
					rdata_r <= '0;
				end
			endcase
		end else begin
			rdata_r <= '0;
		end
	end

	assign reg_rdata = rdata_r;

	default clocking wdcm_cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	svc_restart_a: assert property (svc_valid |=> cnt_r == '0)
		else $error("valid service did not restart window");
	svc_error_a: assert property (svc_bad |=> state_r == wdcm_pkg::WD_DRIVE ##1 !oe_n_r)
		else $error("bad service did not drive fault");
	reset_setting_a: assert property (first_r |-> win_r == `WDCM_WIN_RESET && cm_en_r)
		else $error("settings changed before first service");
	setting_lock_a: assert property (!first_r |=> $stable(win_r) && $stable(cm_en_r))
		else $error("settings changed after lock");
	key_hidden_a: assert property (reg_rd && reg_addr == `WDCM_SVC_ADDR
		|=> reg_rdata[`WDCM_KEY_HI:`WDCM_KEY_LO] == `WDCM_KEY_READ)
		else $error("key field read back nonzero");
	low_freeze_a: assert property (low_power && !idle_exit && !halt_exit
		&& state_r == wdcm_pkg::WD_RUN |=> $stable(cnt_r))
		else $error("window counted in low power");
	halt_resume_a: assert property (halt_exit && resume && !idle_exit && !svc_valid
		&& state_r == wdcm_pkg::WD_RUN
		|=> cnt_r == $past(cnt_r) + ($past(tc_tick && !low_power) ? `WDCM_CNT_ONE : '0))
		else $error("window lost across halt");
	hold_release_a: assert property (state_r == wdcm_pkg::WD_HOLD && !clk_fail && tc_tick
		&& hold_r == `WDCM_HOLD_TC - `WDCM_HOLD_ONE |=> state_r == wdcm_pkg::WD_WAIT ##0 oe_n_r)
		else $error("fault not released after hold");
	busy_ignore_a: assert property (svc_wr && state_r == wdcm_pkg::WD_WAIT && pin_s2_r
		&& !clk_fail |=> state_r == wdcm_pkg::WD_RUN && cnt_r == '0)
		else $error("service during fault was not ignored");
	upper_timeout_a: assert property (timeout |=> state_r == wdcm_pkg::WD_DRIVE)
		else $error("missed upper limit not flagged");
	early_service_a: assert property (svc_take && early |=> state_r == wdcm_pkg::WD_DRIVE)
		else $error("early service not flagged");
	pend_set_a: assert property (pend_set |=> pend_r)
		else $error("pending flag lost");
	clk_hold_a: assert property (clk_fail |=> !oe_n_r)
		else $error("clock fail not driving fault");
endmodule
`default_nettype wire

// *** sim/windowed_watchdog_clock_monitor_bench.sv ***
// self-checking bench of the watchdog and clock monitor
`timescale 1ns/1ns
`default_nettype none
`include "wdcm_regs.svh"
module windowed_watchdog_clock_monitor_bench;
	localparam int CEIL = 60000;
	logic       clock;
	logic       rstn;
	logic       por_n;
	logic       osc_pin;
	logic       osc_run;
	logic       halt_mode;
	logic       idle_mode;
	logic       osc_rc_option;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       pin_out;
	logic       pin_oe_n;
	logic       pin_in;
	logic       idle_timer_pending;
	logic       rd_seen;
	logic [15:0] exp_q[$];
	int         fails;
	int         n_tests;
	int         cycles;
	// weak pull-up on the open-drain fault wire
	assign pin_in = pin_oe_n ? 1'b1 : pin_out;

	wdcm_top #(.CLKMON_LIMIT(64)) u_wdcm_top (
		.clock                 (clock),
		.rstn                  (rstn),
		.por_n                 (por_n),
		.osc_pin               (osc_pin),
		.halt_mode             (halt_mode),
		.idle_mode             (idle_mode),
		.osc_rc_option         (osc_rc_option),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rdata             (reg_rdata),
		.fault_output_pin_out  (pin_out),
		.fault_output_pin_oe_n (pin_oe_n),
		.fault_output_pin_in   (pin_in),
		.idle_timer_pending    (idle_timer_pending)
	);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// one tick every two clocks, far inside the monitor limit
	always @(posedge clock) begin
		if (osc_run) begin
			osc_pin <= ~osc_pin;
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == CEIL) begin
			fails++;
			print_verdict();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clock) rd_seen <= reg_rd;
	always @(negedge clock) begin
		logic [15:0] e;
		if (rd_seen) begin
			e = exp_q.pop_front();
			chk(reg_rdata & e[15:8], e[7:0]);
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back({m, d & m});
		@(posedge clock);
		reg_rd   <= 1'b0;
	endtask

	task automatic no_fault(input int n);
		logic ok;
		ok = 1'b1;
		repeat (n) begin
			@(negedge clock);
			if (pin_oe_n !== 1'b1) ok = 1'b0;
		end
		chk({7'h00, ok}, 8'h01);
	endtask

	// fault must appear, then release after the hold of 16 ticks
	task automatic wait_fault(input logic len);
		int t;
		t = 0;
		while (pin_oe_n !== 1'b0 && t < 800) begin
			@(negedge clock);
			t++;
		end
		chk({7'h00, pin_oe_n}, 8'h00);
		t = 0;
		while (pin_oe_n !== 1'b1 && t < 2000) begin
			@(negedge clock);
			t++;
		end
		chk({7'h00, pin_oe_n}, 8'h01);
		if (len) chk({7'h00, t >= 32 && t <= 44}, 8'h01);
		cyc(4);
	endtask

	logic [3:0] lp [4] = '{4'b0001, 4'b1001, 4'b1111, 4'b1100};
	logic [7:0] bad [4] = '{8'h01, 8'h59, 8'h18, 8'h00};

	initial begin
		logic [7:0] d;
		d = $urandom(32'hD3FE7972);
		rstn = 1'b0; por_n = 1'b0; osc_pin = 1'b0; osc_run = 1'b1;
		halt_mode = 1'b0; idle_mode = 1'b0; osc_rc_option = 1'b0;
		reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
		fails = 0; n_tests = 0; cycles = 0;
		no_fault(16);
		cyc(1);
		rstn <= 1'b1;
		por_n <= 1'b1;
		rd(`WDCM_SVC_ADDR, 8'hC1, 8'hFF);
		rd(`WDCM_STAT_ADDR, 8'h00, 8'hFF);
		rd(8'h55, 8'h00, 8'hFF);
		rd(`WDCM_CTRL_ADDR, 8'h00, 8'hFF);
		wr(`WDCM_SVC_ADDR, 8'h19);
		rd(`WDCM_SVC_ADDR, 8'h01, 8'hFF);
		rd(`WDCM_STAT_ADDR, 8'h08, 8'hFF);
		wr(`WDCM_SVC_ADDR, 8'h19);
		wait_fault(1);
		// last entry is a random wrong key
		d = $urandom;
		if (d[5:1] == 5'h0C) d[1] = 1'b1;
		bad[3] = {2'b00, d[5:0] | 6'h01};
		for (int i = 0; i < 4; i++) begin
			cyc(600);
			wr(`WDCM_SVC_ADDR, bad[i]);
			wait_fault(1);
		end
		repeat (3) begin
			cyc(520 + $urandom_range(900));
			wr(`WDCM_SVC_ADDR, 8'h19);
			no_fault(40);
		end
		// halt and idle exits: reload or resume the window count
		for (int i = 0; i < 4; i++) begin
			wr(`WDCM_CTRL_ADDR, {7'h00, lp[i][1]});
			rd(`WDCM_CTRL_ADDR, {7'h00, lp[i][1]}, 8'hFF);
			osc_rc_option <= lp[i][2];
			cyc(600);
			wr(`WDCM_SVC_ADDR, 8'h19);
			cyc(700);
			if (lp[i][3]) halt_mode <= 1'b1; else idle_mode <= 1'b1;
			no_fault(20);
			halt_mode <= 1'b0;
			idle_mode <= 1'b0;
			cyc(4);
			wr(`WDCM_SVC_ADDR, 8'h19);
			if (lp[i][0]) wait_fault(1);
			else no_fault(60);
		end
		cyc(600);
		wr(`WDCM_SVC_ADDR, 8'h19);
		no_fault(16000);
		wait_fault(1);
		chk({7'h00, idle_timer_pending}, 8'h01);
		wr(`WDCM_STAT_ADDR, 8'h01);
		rd(`WDCM_STAT_ADDR, 8'h00, 8'h01);
		// stopped clock during halt
		halt_mode <= 1'b1;
		osc_run <= 1'b0;
		fork
			begin
				cyc(300);
				osc_run <= 1'b1;
			end
			wait_fault(0);
		join
		halt_mode <= 1'b0;
		rstn <= 1'b0;
		no_fault(16);
		cyc(1);
		rstn <= 1'b1;
		rd(`WDCM_SVC_ADDR, 8'hC1, 8'hFF);
		wr(`WDCM_SVC_ADDR, 8'h41);
		// a good first service written while the fault is out must not land
		fork
			begin
				cyc(10);
				wr(`WDCM_SVC_ADDR, 8'h59);
			end
			wait_fault(1);
		join
		rd(`WDCM_SVC_ADDR, 8'hC1, 8'hFF);
		wr(`WDCM_SVC_ADDR, 8'h59);
		no_fault(40);
		rd(`WDCM_SVC_ADDR, 8'h41, 8'hFF);
		cyc(4);
		print_verdict();
	end
endmodule
`default_nettype wire
